// [mcd_pkg.sv]
// Constants, opcodes and carrier types for the four-bit datapath.
// Assumes a single 50 MHz clock domain and no other package.
package mcd_pkg;

	// Clock and instruction timing
	localparam int CLK_MHZ = 50;
	localparam int INSTR_CLOCKS = 6;
	localparam logic [2:0] PHASE_FETCH = 3'h0;
	localparam logic [2:0] PHASE_LAST = 3'(INSTR_CLOCKS - 1);

	// Memory organisation
	localparam int FILES = 4;
	localparam int WORDS_PER_FILE = 16;
	localparam int RAM_WORDS = FILES * WORDS_PER_FILE;
	localparam int DEC_ENTRIES = 32;

	// Register bus map (byte addresses, one aligned word each)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATE = 8'h04;
	localparam logic [7:0] ADDR_RAM_PTR = 8'h08;
	localparam logic [7:0] ADDR_RAM_DATA = 8'h0C;
	localparam logic [0:0] DEC_TBL_SEL = 1'h1;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
	localparam logic CTRL_RUN_RST = 1'h0;
	localparam int CTRL_RUN_BIT = 0;

	// Field positions in the state word
	localparam int ST_ACC_LSB = 0;
	localparam int ST_PTR_LSB = 4;
	localparam int ST_FILE_LSB = 8;
	localparam int ST_STATUS_BIT = 10;
	localparam int ST_LATCH_BIT = 11;
	localparam int ST_DIN_LSB = 12;
	localparam int ST_PHASE_LSB = 17;

	// Arithmetic constants
	localparam logic [4:0] K_ONE = 5'h01;
	localparam logic [4:0] K_SIX = 5'h06;
	localparam logic [4:0] K_EIGHT = 5'h08;
	localparam logic [4:0] K_TEN = 5'h0A;
	localparam logic [3:0] NIB_ZERO = 4'h0;

	// Opcode groups
	localparam logic [1:0] GRP_BRANCH = 2'h2;
	localparam logic [3:0] NIB_BITOPS = 4'h3;
	localparam logic [3:0] NIB_LDP = 4'h1;
	localparam logic [3:0] NIB_CONST_TO_POINTER = 4'h4;
	localparam logic [3:0] NIB_POINTER_NE_CONSTANT = 4'h5;
	localparam logic [3:0] NIB_CONST_STORE_ADVANCE = 4'h6;
	localparam logic [3:0] NIB_ACC_LE_CONSTANT = 4'h7;
	localparam logic [1:0] BIT_SET_RAM_BIT = 2'h0;
	localparam logic [1:0] BIT_CLEAR_RAM_BIT = 2'h1;
	localparam logic [1:0] BIT_TEST_RAM_BIT = 2'h2;
	localparam logic [1:0] BIT_LOAD_FILE_SELECT = 2'h3;

	// Full-byte opcodes
	localparam logic [7:0] OP_INVERT_FILE_SELECT = 8'h00;
	localparam logic [7:0] OP_ADD_EIGHT = 8'h01;
	localparam logic [7:0] OP_POINTER_NE_ACC = 8'h02;
	localparam logic [7:0] OP_ACC_TO_MEM = 8'h03;
	localparam logic [7:0] OP_ACC_TO_MEM_ZERO = 8'h04;
	localparam logic [7:0] OP_ADD_TEN = 8'h05;
	localparam logic [7:0] OP_ADD_SIX = 8'h06;
	localparam logic [7:0] OP_ACC_DECREMENT = 8'h07;
	localparam logic [7:0] OP_INPUTS_TO_ACC = 8'h08;
	localparam logic [7:0] OP_INPUTS_NONZERO_TEST = 8'h09;
	localparam logic [7:0] OP_ACC_TO_DECODE = 8'h0A;
	localparam logic [7:0] OP_CLEAR_DECODE_INPUT = 8'h0B;
	localparam logic [7:0] OP_LOWER_SELECT_LINE = 8'h0C;
	localparam logic [7:0] OP_RAISE_SELECT_LINE = 8'h0D;
	localparam logic [7:0] OP_ACC_INCREMENT = 8'h0E;
	localparam logic [7:0] OP_ACC_STORE_ADVANCE = 8'h20;
	localparam logic [7:0] OP_MEM_TO_ACC = 8'h21;
	localparam logic [7:0] OP_MEM_TO_POINTER = 8'h22;
	localparam logic [7:0] OP_POINTER_TO_ACC = 8'h23;
	localparam logic [7:0] OP_ACC_TO_POINTER = 8'h24;
	localparam logic [7:0] OP_ADD_MEMORY = 8'h25;
	localparam logic [7:0] OP_MEMORY_NONZERO_TEST = 8'h26;
	localparam logic [7:0] OP_SUBTRACT_FROM_MEMORY = 8'h27;
	localparam logic [7:0] OP_LOAD_MEMORY_PLUS_ONE = 8'h28;
	localparam logic [7:0] OP_ACC_LE_MEMORY = 8'h29;
	localparam logic [7:0] OP_LOAD_MEMORY_MINUS_ONE = 8'h2A;
	localparam logic [7:0] OP_POINTER_INCREMENT = 8'h2B;
	localparam logic [7:0] OP_POINTER_DECREMENT = 8'h2C;
	localparam logic [7:0] OP_NEGATE_ACC = 8'h2D;
	localparam logic [7:0] OP_EXCHANGE_MEM_ACC = 8'h2E;
	localparam logic [7:0] OP_CLEAR_ACC = 8'h2F;

	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} mcd_bus_t;

endpackage

// [mcd_datapath.sv]
// Four-bit microcomputer datapath: RAM, pointers, adder and status logic,
// select lines, decoded output port and input port.
// Assumes instruction bytes arrive on INSTR from logic on REF_CLK while
// FETCH is high, and that the input lines come straight from pins.
//
// Summary of operation
// - RAM holds 64 four-bit words in four files of sixteen words.
// - File select picks the file; loaded from instruction or inverted.
// - Pointer loads from constant, RAM or accumulator; steps up or down.
// - Set, clear and test act on one addressed RAM bit chosen by field.
// - Parameterised counts of decoded output lines (eight by default) and select lines.
// - Pointer picks one select line; raise or lower it, others hold.
// - Output lines decode the five-bit decode input register via table.
// - Only the pointer versus accumulator compare changes the status latch.
// - One instruction copies accumulator and latch in; another clears it.
// - Input lines set status when nonzero, or copy into the accumulator.
// - Arithmetic other than accumulator increment, compares and tests set status; all others force one.
// - Add memory puts sum in accumulator, carry into status.
// - Memory minus accumulator into accumulator, status one without borrow.
// - Memory plus or minus one into accumulator, status carry or no-borrow.
// - Pointer increment gives carry; decrement gives no-borrow.
// - Accumulator decrement gives no-borrow; zero wraps to fifteen.
// - Add six, eight or ten to accumulator, status gets carry.
// - Accumulator becomes two's complement; status one when it was zero.
// - Status one when accumulator at most the RAM word; operands unchanged.
// - Pointer inequality sets status; against accumulator also the latch.
// - Memory nonzero test and single-bit test set status from the word.
// - Each byte instruction takes exactly six clocks whatever its outcome.
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module mcd_datapath
#(
	parameter int SEL_LINES = 16,
	parameter int DEC_WIDTH = 8
) (
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire mcd_pkg::mcd_bus_t BUS_REQ,
	output logic [31:0] BUS_RDATA,
	input wire logic [7:0] INSTR,
	output logic FETCH,
	input wire logic [3:0] KEY_IN,
	output logic [SEL_LINES-1:0] SEL_OUT,
	output logic [DEC_WIDTH-1:0] DEC_OUT
);
	import mcd_pkg::*;

	// Architectural state
	logic [3:0] acc_q;
	logic [3:0] acc_d;
	logic [3:0] ptr_q;
	logic [3:0] ptr_d;
	logic [1:0] file_q;
	logic [1:0] file_d;
	logic status_q;
	logic status_d;
	logic latch_q;
	logic latch_d;
	logic [4:0] din_q;
	logic [4:0] din_d;
	logic [7:0] ir_q;
	logic [2:0] phase_q;
	logic [2:0] phase_d;
	logic run_q;
	logic fetch_q;
	logic [5:0] ram_ptr_q;
	logic [31:0] rdata_q;
	logic [SEL_LINES-1:0] sel_q;
	logic [DEC_WIDTH-1:0] dec_out_q;
	logic [3:0] ram_q [RAM_WORDS];
	logic [DEC_WIDTH-1:0] dec_tbl_q [DEC_ENTRIES];

	// Input pins pass two flops before any use
	logic [3:0] key_s1_q;
	logic [3:0] key_s2_q;

	// Execution side effects
	logic mem_we;
	logic [3:0] mem_wd;
	logic sel_raise;
	logic sel_lower;

	// Decode
	wire exec = (phase_q == PHASE_LAST);
	wire take = run_q && (phase_q == PHASE_FETCH);
	wire [5:0] ram_addr = {file_q, ptr_q};
	wire [3:0] mem = ram_q[ram_addr];
	wire [3:0] cfield = {ir_q[0], ir_q[1], ir_q[2], ir_q[3]};
	wire [1:0] bfield = {ir_q[0], ir_q[1]};
	// Branch and call groups both have the top bit set
	wire is_branch = (ir_q[7:6] & GRP_BRANCH) == GRP_BRANCH;
	wire is_nibble = !is_branch && ir_q[6];
	wire is_bitop = (ir_q[7:4] == NIB_BITOPS);
	wire [4:0] acc5 = {1'b0, acc_q};
	wire [4:0] mem5 = {1'b0, mem};
	wire [4:0] ptr5 = {1'b0, ptr_q};
	wire [4:0] ptr_up = ptr5 + K_ONE;
	wire [4:0] ptr_dn = ptr5 - K_ONE;

	// Bus decode
	wire bus_ctrl = (BUS_REQ.addr == ADDR_CTRL);
	wire bus_state = (BUS_REQ.addr == ADDR_STATE);
	wire bus_rptr = (BUS_REQ.addr == ADDR_RAM_PTR);
	wire bus_rdat = (BUS_REQ.addr == ADDR_RAM_DATA);
	wire bus_tbl = (BUS_REQ.addr[7] == DEC_TBL_SEL);
	wire [4:0] tbl_idx = BUS_REQ.addr[6:2];
	wire [31:0] state_word = {
		12'h000,
		phase_q,
		din_q,
		latch_q,
		status_q,
		file_q,
		ptr_q,
		acc_q
	};
	wire [31:0] rd_mux =
		bus_ctrl ? {31'h0000_0000, run_q} :
		bus_state ? state_word :
		bus_rptr ? {26'h000_0000, ram_ptr_q} :
		bus_rdat ? {28'h000_0000, ram_q[ram_ptr_q]} :
		bus_tbl ? {{(32 - DEC_WIDTH){1'b0}}, dec_tbl_q[tbl_idx]} :
		RD_ZERO;

	always_comb begin
		logic [4:0] r;
		r = 5'h00;
		acc_d = acc_q;
		ptr_d = ptr_q;
		file_d = file_q;
		latch_d = latch_q;
		din_d = din_q;
		status_d = 1'b1;
		mem_we = 1'b0;
		mem_wd = acc_q;
		sel_raise = 1'b0;
		sel_lower = 1'b0;
		if (is_branch) begin
			status_d = 1'b1;
		end else if (is_nibble || ir_q[7:4] == NIB_LDP) begin
			unique case (ir_q[7:4])
				NIB_CONST_TO_POINTER: begin
					ptr_d = cfield;
				end
				NIB_POINTER_NE_CONSTANT: begin
					status_d = (ptr_q != cfield);
				end
				NIB_CONST_STORE_ADVANCE: begin
					mem_we = 1'b1;
					mem_wd = cfield;
					ptr_d = ptr_up[3:0];
				end
				NIB_ACC_LE_CONSTANT: begin
					status_d = (acc_q <= cfield);
				end
				default: begin
					status_d = 1'b1;
				end
			endcase
		end else if (is_bitop) begin
			unique case (ir_q[3:2])
				BIT_SET_RAM_BIT: begin
					mem_we = 1'b1;
					mem_wd = mem | (4'h1 << bfield);
				end
				BIT_CLEAR_RAM_BIT: begin
					mem_we = 1'b1;
					mem_wd = mem & ~(4'h1 << bfield);
				end
				BIT_TEST_RAM_BIT: begin
					status_d = mem[bfield];
				end
				BIT_LOAD_FILE_SELECT: begin
					file_d = bfield;
				end
			endcase
		end else begin
			unique case (ir_q)
				OP_INVERT_FILE_SELECT: file_d = ~file_q;
				OP_ADD_EIGHT: begin
					r = acc5 + K_EIGHT;
					acc_d = r[3:0];
					status_d = r[4];
				end
				OP_ADD_TEN: begin
					r = acc5 + K_TEN;
					acc_d = r[3:0];
					status_d = r[4];
				end
				OP_ADD_SIX: begin
					r = acc5 + K_SIX;
					acc_d = r[3:0];
					status_d = r[4];
				end
				OP_POINTER_NE_ACC: begin
					status_d = (ptr_q != acc_q);
					latch_d = (ptr_q != acc_q);
				end
				OP_ACC_TO_MEM: mem_we = 1'b1;
				OP_ACC_TO_MEM_ZERO: begin
					mem_we = 1'b1;
					acc_d = NIB_ZERO;
				end
				OP_ACC_DECREMENT: begin
					r = acc5 - K_ONE;
					acc_d = r[3:0];
					status_d = ~r[4];
				end
				OP_INPUTS_TO_ACC: acc_d = key_s2_q;
				OP_INPUTS_NONZERO_TEST: begin
					status_d = (key_s2_q != NIB_ZERO);
				end
				OP_ACC_TO_DECODE: din_d = {latch_q, acc_q};
				OP_CLEAR_DECODE_INPUT: din_d = 5'h00;
				OP_LOWER_SELECT_LINE: sel_lower = 1'b1;
				OP_RAISE_SELECT_LINE: sel_raise = 1'b1;
				OP_ACC_INCREMENT: begin
					r = acc5 + K_ONE;
					acc_d = r[3:0];
				end
				OP_ACC_STORE_ADVANCE: begin
					mem_we = 1'b1;
					ptr_d = ptr_up[3:0];
				end
				OP_MEM_TO_ACC: acc_d = mem;
				OP_MEM_TO_POINTER: ptr_d = mem;
				OP_POINTER_TO_ACC: acc_d = ptr_q;
				OP_ACC_TO_POINTER: ptr_d = acc_q;
				OP_ADD_MEMORY: begin
					r = acc5 + mem5;
					acc_d = r[3:0];
					status_d = r[4];
				end
				OP_MEMORY_NONZERO_TEST: begin
					status_d = (mem != NIB_ZERO);
				end
				OP_SUBTRACT_FROM_MEMORY: begin
					r = mem5 - acc5;
					acc_d = r[3:0];
					status_d = ~r[4];
				end
				OP_LOAD_MEMORY_PLUS_ONE: begin
					r = mem5 + K_ONE;
					acc_d = r[3:0];
					status_d = r[4];
				end
				OP_ACC_LE_MEMORY: status_d = (acc_q <= mem);
				OP_LOAD_MEMORY_MINUS_ONE: begin
					r = mem5 - K_ONE;
					acc_d = r[3:0];
					status_d = ~r[4];
				end
				OP_POINTER_INCREMENT: begin
					ptr_d = ptr_up[3:0];
					status_d = ptr_up[4];
				end
				OP_POINTER_DECREMENT: begin
					ptr_d = ptr_dn[3:0];
					status_d = ~ptr_dn[4];
				end
				OP_NEGATE_ACC: begin
					r = {1'b0, ~acc_q} + K_ONE;
					acc_d = r[3:0];
					status_d = r[4];
				end
				OP_EXCHANGE_MEM_ACC: begin
					mem_we = 1'b1;
					acc_d = mem;
				end
				OP_CLEAR_ACC: acc_d = NIB_ZERO;
				// Only the one unused byte code lands here and forces status; page load forces it in the nibble case
				default: status_d = 1'b1;
			endcase
		end
	end

	// Six-clock instruction cycle; an idle core waits in the fetch phase
	assign phase_d = exec ? PHASE_FETCH :
		(phase_q != PHASE_FETCH || run_q) ? phase_q + 3'h1 : phase_q;

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			phase_q <= PHASE_FETCH;
			fetch_q <= 1'b0;
			ir_q <= OP_ACC_INCREMENT;
		end else begin
			phase_q <= phase_d;
			// High during the fetch phase cycle, when INSTR is taken
			fetch_q <= run_q && (phase_d == PHASE_FETCH);
			if (take) begin
				ir_q <= INSTR;
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			key_s1_q <= NIB_ZERO;
			key_s2_q <= NIB_ZERO;
		end else begin
			key_s1_q <= KEY_IN;
			key_s2_q <= key_s1_q;
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			acc_q <= NIB_ZERO;
			ptr_q <= NIB_ZERO;
			file_q <= 2'h0;
			status_q <= 1'b1;
			latch_q <= 1'b0;
			din_q <= 5'h00;
		end else if (exec) begin
			acc_q <= acc_d;
			ptr_q <= ptr_d;
			file_q <= file_d;
			status_q <= status_d;
			latch_q <= latch_d;
			din_q <= din_d;
		end
	end

	// RAM holds data only, so it carries no reset
	always_ff @(posedge REF_CLK) begin
		if (exec && mem_we) begin
			ram_q[ram_addr] <= mem_wd;
		end
	end

	// Select lines: pointer values beyond the line count touch nothing
	for (genvar i = 0; i < SEL_LINES; i++) begin : g_sel
		wire hit = (ptr_q == 4'(i));
		always_ff @(posedge REF_CLK or negedge RESET_N) begin
			if (!RESET_N) begin
				sel_q[i] <= 1'b0;
			end else if (exec && hit && sel_raise) begin
				sel_q[i] <= 1'b1;
			end else if (exec && hit && sel_lower) begin
				sel_q[i] <= 1'b0;
			end
		end
	end

	// Decode table is software loaded; output trails the input by one clock
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			dec_out_q <= '0;
			for (int j = 0; j < DEC_ENTRIES; j++) begin
				dec_tbl_q[j] <= '0;
			end
		end else begin
			dec_out_q <= dec_tbl_q[din_q];
			if (BUS_REQ.wr && bus_tbl) begin
				dec_tbl_q[tbl_idx] <= BUS_REQ.wdata[DEC_WIDTH-1:0];
			end
		end
	end

	// Register bus slave, read data in the cycle after the strobe
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			run_q <= CTRL_RUN_RST;
			ram_ptr_q <= 6'h00;
			rdata_q <= RD_ZERO;
		end else begin
			if (BUS_REQ.wr && bus_ctrl) begin
				run_q <= BUS_REQ.wdata[CTRL_RUN_BIT];
			end
			if (BUS_REQ.wr && bus_rptr) begin
				ram_ptr_q <= BUS_REQ.wdata[5:0];
			end
			rdata_q <= BUS_REQ.rd ? rd_mux : RD_ZERO;
		end
	end

	assign BUS_RDATA = rdata_q;
	assign FETCH = fetch_q;
	assign SEL_OUT = sel_q;
	assign DEC_OUT = dec_out_q;

endmodule

// [mcd_datapath_props.sv]
// Port checker for the four-bit datapath.
// Assumes binding to mcd_datapath and that run is never cleared.
`timescale 1ns/10ps
module mcd_props
#(
	parameter int SEL_LINES = 16,
	parameter int DEC_WIDTH = 8
) (
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire mcd_pkg::mcd_bus_t BUS_REQ,
	input wire logic [31:0] BUS_RDATA,
	input wire logic FETCH,
	input wire logic [SEL_LINES-1:0] SEL_OUT,
	input wire logic [DEC_WIDTH-1:0] DEC_OUT
);
	import mcd_pkg::*;
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (!RESET_N);
	wire rd_low = BUS_REQ.rd && !BUS_REQ.addr[7];
	sequence gap_s;
		!FETCH [*5] ##1 FETCH;
	endsequence
	// A table write may also move the decoded output
	sequence cause_s;
		$past(FETCH) || $past(BUS_REQ.wr, 2);
	endsequence
	fetch_gap_a: assert property (FETCH |=> gap_s)
		else $error("instruction cycle not six clocks");
	idle_zero_a: assert property (
		!BUS_REQ.rd |=> BUS_RDATA == RD_ZERO)
		else $error("read data not zero when idle");
	narrow_read_a: assert property (
		rd_low && BUS_REQ.addr != ADDR_STATE |=> BUS_RDATA[31:6] == 26'h0)
		else $error("narrow register upper bits set");
	state_word_a: assert property (
		BUS_REQ.rd && BUS_REQ.addr == ADDR_STATE |=>
		BUS_RDATA[31:20] == 12'h000 && BUS_RDATA[19:17] <= PHASE_LAST)
		else $error("state word malformed");
	table_read_a: assert property (
		BUS_REQ.rd && BUS_REQ.addr[7] |=> BUS_RDATA[31:8] == 24'h0)
		else $error("table entry wider than eight bits");
	sel_commit_a: assert property (!$stable(SEL_OUT) |-> FETCH)
		else $error("select lines moved off commit");
	sel_single_a: assert property (
		$countones(SEL_OUT ^ $past(SEL_OUT)) <= 1)
		else $error("more than one select line moved");
	dec_commit_a: assert property (!$stable(DEC_OUT) |-> cause_s)
		else $error("decoded output moved without cause");
endmodule

// [mcd_keypad.sv]
// Key pad on the four input lines.
// Assumes the bench changes the pressed keys well before they are read.
`timescale 1ns/10ps
module mcd_keypad #(
	parameter int SEL_LINES = 16
) (
	input wire logic [SEL_LINES-1:0] sel,
	input wire logic [3:0] pressed,
	output logic [3:0] keys
);
	// Only the row on select line 0 is wired; unscanned rows read released
	assign keys = sel[0] ? pressed : 4'h0;
endmodule

// [mcd_datapath_tb_top.sv]
// Self-checking bench for mcd_datapath, small select-line variant.
// Assumes mcd_pkg, mcd_props and mcd_keypad are compiled first.
`timescale 1ns/10ps
module mcd_datapath_tb_top;
	import mcd_pkg::*;
	localparam int SEL_CNT = 11;
	logic ref_clk = 1'h0, reset_n = 1'h0;
	mcd_bus_t bus = '0;
	logic [7:0] instr = 8'h10;
	logic [3:0] pr = 4'h0, keys, acc = 4'h0, ptr = 4'h0;
	logic [31:0] rdata;
	logic fetch, st = 1'h1, lat = 1'h0;
	logic [SEL_CNT-1:0] sel, m_sel = '0;
	logic [7:0] dec;
	logic [1:0] fil = 2'h0;
	logic [4:0] din = 5'h00;
	logic [3:0] ram [64];
	logic [7:0] tbl [32];
	int err_count = 0, comparisons = 0, seed = 16873;

	mcd_datapath #(.SEL_LINES(SEL_CNT), .DEC_WIDTH(8)) u_mcd_datapath (
		.REF_CLK(ref_clk), .RESET_N(reset_n), .BUS_REQ(bus),
		.BUS_RDATA(rdata), .INSTR(instr), .FETCH(fetch), .KEY_IN(keys),
		.SEL_OUT(sel), .DEC_OUT(dec));
	mcd_keypad #(.SEL_LINES(SEL_CNT)) u_mcd_keypad (.sel(sel), .pressed(pr),
		.keys(keys));

	always #10 ref_clk = ~ref_clk;

	task automatic complete_run();
		if (err_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One gap cycle after each access keeps strobes single-driven
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] v);
		bus <= '{a, d, w, !w};
		@(posedge ref_clk);
		bus <= '{a, d, 1'h0, 1'h0};
		#1 v = rdata;
		@(posedge ref_clk);
	endtask

	// Returns on the edge that captures the byte on instr
	task automatic sync();
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1 n++;
		end while (fetch !== 1'h1 && n < 20);
		chk("fetch", fetch, 1'h1);
		@(posedge ref_clk);
	endtask

	// Returns {no borrow, difference}
	function automatic logic [4:0] nb(input logic [3:0] x, input logic [4:0] y);
		logic [4:0] d;
		d = {1'h0, x} - y;
		return {~d[4], d[3:0]};
	endfunction

	task automatic model(input logic [7:0] op);
		logic [5:0] a;
		logic [3:0] m, c;
		logic [1:0] b;
		a = {fil, ptr};
		m = ram[a];
		c = {op[0], op[1], op[2], op[3]};
		b = {op[0], op[1]};
		st = 1'h1;
		case (op)
		OP_INVERT_FILE_SELECT: fil = ~fil;
		OP_ADD_EIGHT: {st, acc} = acc + K_EIGHT;
		OP_ADD_TEN: {st, acc} = acc + K_TEN;
		OP_ADD_SIX: {st, acc} = acc + K_SIX;
		OP_POINTER_NE_ACC: begin
			st = ptr != acc;
			lat = st;
		end
		OP_ACC_TO_MEM: ram[a] = acc;
		OP_ACC_TO_MEM_ZERO: {ram[a], acc} = {acc, 4'h0};
		OP_ACC_DECREMENT: {st, acc} = nb(acc, K_ONE);
		OP_INPUTS_TO_ACC: acc = m_sel[0] ? pr : 4'h0;
		OP_INPUTS_NONZERO_TEST: st = m_sel[0] && pr != 4'h0;
		OP_ACC_TO_DECODE: din = {lat, acc};
		OP_CLEAR_DECODE_INPUT: din = 5'h00;
		OP_LOWER_SELECT_LINE: if (ptr < SEL_CNT) m_sel[ptr] = 1'h0;
		OP_RAISE_SELECT_LINE: if (ptr < SEL_CNT) m_sel[ptr] = 1'h1;
		OP_ACC_INCREMENT: acc = acc + 4'h1;
		OP_ACC_STORE_ADVANCE: {ram[a], ptr} = {acc, ptr + 4'h1};
		OP_MEM_TO_ACC: acc = m;
		OP_MEM_TO_POINTER: ptr = m;
		OP_POINTER_TO_ACC: acc = ptr;
		OP_ACC_TO_POINTER: ptr = acc;
		OP_ADD_MEMORY: {st, acc} = acc + m;
		OP_MEMORY_NONZERO_TEST: st = m != 4'h0;
		OP_SUBTRACT_FROM_MEMORY: {st, acc} = nb(m, {1'h0, acc});
		OP_LOAD_MEMORY_PLUS_ONE: {st, acc} = m + K_ONE;
		OP_ACC_LE_MEMORY: st = acc <= m;
		OP_LOAD_MEMORY_MINUS_ONE: {st, acc} = nb(m, K_ONE);
		OP_POINTER_INCREMENT: {st, ptr} = ptr + K_ONE;
		OP_POINTER_DECREMENT: {st, ptr} = nb(ptr, K_ONE);
		OP_NEGATE_ACC: {st, acc} = {1'h0, ~acc} + K_ONE;
		OP_EXCHANGE_MEM_ACC: {ram[a], acc} = {acc, m};
		OP_CLEAR_ACC: acc = 4'h0;
		default:
			case (op[7:4])
			NIB_BITOPS:
				case (op[3:2])
				BIT_SET_RAM_BIT: ram[a][b] = 1'h1;
				BIT_CLEAR_RAM_BIT: ram[a][b] = 1'h0;
				BIT_TEST_RAM_BIT: st = m[b];
				default: fil = b;
				endcase
			NIB_CONST_TO_POINTER: ptr = c;
			NIB_POINTER_NE_CONSTANT: st = ptr != c;
			NIB_CONST_STORE_ADVANCE: {ram[a], ptr} = {c, ptr + 4'h1};
			NIB_ACC_LE_CONSTANT: st = acc <= c;
			default: st = 1'h1;
			endcase
		endcase
	endtask

	// A filler byte follows each op; state is read before it commits
	task automatic exec(input logic [7:0] op);
		logic [31:0] v;
		instr <= op;
		pr <= 4'($random(seed));
		sync();
		instr <= 8'h10;
		repeat (5) @(posedge ref_clk);
		model(op);
		xfer(1'h0, ADDR_STATE, 32'h0, v);
		chk("state", v[16:0], {din, lat, st, fil, ptr, acc});
		chk("sel", sel, m_sel);
		chk("dec", dec, tbl[din]);
	endtask

	initial begin
		logic [31:0] v;
		logic [7:0] dir [$];
		dir = {OP_CLEAR_ACC, OP_ACC_DECREMENT, OP_CLEAR_ACC, OP_NEGATE_ACC,
			8'h4F, 8'h7F, OP_POINTER_INCREMENT, OP_POINTER_DECREMENT, 8'h43,
			OP_RAISE_SELECT_LINE, 8'h40, OP_RAISE_SELECT_LINE,
			OP_INPUTS_TO_ACC, OP_INPUTS_NONZERO_TEST, OP_POINTER_NE_ACC,
			OP_ACC_TO_DECODE, OP_CLEAR_DECODE_INPUT, OP_INVERT_FILE_SELECT,
			OP_LOWER_SELECT_LINE, 8'hC5};
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'h1;
		@(posedge ref_clk);
		xfer(1'h0, ADDR_STATE, 32'h0, v);
		chk("reset state", v[16:0], 17'h00400);
		for (int i = 0; i < 32; i++) begin
			tbl[i] = 8'($random(seed));
			xfer(1'h1, 8'h80 + 8'(i * 4), {24'h0, tbl[i]}, v);
		end
		xfer(1'h0, 8'h84, 32'h0, v);
		chk("table", v, tbl[1]);
		xfer(1'h0, 8'h40, 32'h0, v);
		chk("unmapped", v, 32'h0);
		xfer(1'h1, ADDR_CTRL, 32'h1, v);
		sync();
		// Every word is written before any op may read it
		for (int f = 0; f < 4; f++) begin
			exec(8'h3C | {6'h00, f[0], f[1]});
			exec(8'h40);
			repeat (16) exec(8'h60 | (8'($random(seed)) & 8'h0F));
		end
		foreach (dir[i]) exec(dir[i]);
		repeat (300) exec(8'($random(seed)) & 8'h7F);
		for (int i = 0; i < 64; i++) begin
			xfer(1'h1, ADDR_RAM_PTR, i, v);
			xfer(1'h0, ADDR_RAM_DATA, 32'h0, v);
			chk("ram", v, ram[i]);
		end
		complete_run();
	end

	// About 5000 clocks of work; thirty thousand clocks is a hang
	initial begin
		#600000;
		err_count++;
		complete_run();
	end
endmodule

bind mcd_datapath mcd_props #(.SEL_LINES(SEL_LINES), .DEC_WIDTH(DEC_WIDTH))
	u_mcd_props (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .BUS_REQ(BUS_REQ),
	.BUS_RDATA(BUS_RDATA), .FETCH(FETCH), .SEL_OUT(SEL_OUT),
	.DEC_OUT(DEC_OUT));
